// >>> core/dpsr_consts.svh
// constants of the burst-of-two dual-port sram interface
`ifndef DPSR_CONSTS_SVH
`define DPSR_CONSTS_SVH
`define DPSR_ADDR_W 18
`define DPSR_DATA_W 18
`define DPSR_LO_MSB 8
`define DPSR_HI_LSB 9
`define DPSR_BURST_LEN 2
`define DPSR_FIFO_DEPTH 16
`define DPSR_MEM_AW 4
`define DPSR_DUE_W 3
`define DPSR_CLK_K 3
`define DPSR_CLK_KN 2
`define DPSR_CLK_C 1
`define DPSR_CLK_CN 0
`endif

// >>> core/dpsr_pkg.sv
// types shared by the sram interface design
package dpsr_pkg;
`include "dpsr_consts.svh"
  typedef logic [`DPSR_DATA_W-1:0] dpsr_word_t;
  typedef struct packed {
    logic [3:0] clks;
    logic rd_sel_n;
    logic wr_sel_n;
    logic low_byte_write_n;
    logic high_byte_write_n;
    logic [`DPSR_ADDR_W-1:0] addr;
    dpsr_word_t d;
  } dpsr_link_t;
  typedef struct packed {
    logic first;
    dpsr_word_t data;
  } dpsr_rdw_t;
  typedef enum logic [1:0] {
    rd_idle = 2'b01,
    rd_second = 2'b10
  } dpsr_rd_st_t;
  typedef enum logic [1:0] {
    write_state_idle = 2'b01,
    write_state_go = 2'b10
  } dpsr_wr_st_t;
endpackage

// >>> core/dpsr_top.sv
// read fifo and device-side burst-of-two dual-port sram logic
// How it works
// - each address gets one low bit and moves two words, offset 0 then 1.
// - a low read or write select starts that cycle, both high an idle_cycle.
// - read and write machines are independent and may run in the same cycle.
// - both machines start only on a rising edge of K; writes finish at K# rise, reads fetch word two once a fifo slot is free.
// - with C and C# both held high, read data launches on K and K# rises.
// - port selects are sampled only at K rise, never at K#.
// - byte strobes, sampled at each K and K# rise, gate bits 0-8 and 9-17.
// - with all clocks stopped nothing starts or launches; only a started read still fetches word two into the fifo.
// - read data outputs stay high impedance until a read drives them.
// - the read data bus is driven only by reads, never by writes.
`timescale 1ns/1ps
`include "dpsr_consts.svh"

// ****************************************
// fifo
// ****************************************
module dpsr_fifo #(
  parameter int W = `DPSR_DATA_W + 1,
  parameter int DEPTH = `DPSR_FIFO_DEPTH
) (
  input logic clk_sys_i,
  input logic resetn_i,
  input logic in_valid_i,
  output logic in_ready_o,
  input logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  import dpsr_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rp;
    logic [AW-1:0] wp;
    logic [AW:0] cnt;
  } dpsr_fifo_st_t;

  dpsr_fifo_st_t r;
  dpsr_fifo_st_t next_r;
  logic push;
  logic pop;

  // wraps explicitly so depth need not be a power of two
  function automatic logic [AW-1:0] dpsr_ptr_inc(input logic [AW-1:0] p);
    dpsr_ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_o = (r.cnt != (AW + 1)'(DEPTH));
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o = r.mem[r.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_data_i;
      next_r.wp = dpsr_ptr_inc(r.wp);
    end
    if (pop) begin
      next_r.rp = dpsr_ptr_inc(r.rp);
    end
    next_r.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// ****************************************
// device top
// ****************************************
module dpsr_top #(
  parameter int MEM_AW = `DPSR_MEM_AW,
  parameter int FIFO_DEPTH = `DPSR_FIFO_DEPTH
) (
  input logic clk_sys_i,
  input logic resetn_i,
  input dpsr_pkg::dpsr_link_t link_i,
  output dpsr_pkg::dpsr_word_t q_o,
  output logic q_oe_n_o
);
  import dpsr_pkg::*;
  localparam int MA = MEM_AW + 1;
  localparam int FW = `DPSR_DATA_W + 1;

  typedef struct packed {
    dpsr_link_t s1;
    dpsr_link_t s2;
    dpsr_link_t s3;
    logic [3:0] clk_f;
    logic [1:0] fill;
    dpsr_rd_st_t rd_st;
    dpsr_wr_st_t wr_st;
    logic [MEM_AW-1:0] wr_addr;
    logic [MEM_AW-1:0] rd_addr;
    logic push_pend;
    dpsr_rdw_t push_word;
    logic load_prev;
    logic [`DPSR_DUE_W-1:0] due;
    logic second_due;
    dpsr_word_t q;
    logic q_oe_n;
    logic [2**MA-1:0][`DPSR_DATA_W-1:0] mem;
  } dpsr_st_t;

  dpsr_st_t r;
  dpsr_st_t next_r;
  logic [3:0] rise;
  logic k_rise;
  logic kn_rise;
  logic l_rise;
  logic l_nrise;
  logic c_held;
  logic accepted;
  logic inc;
  logic pop0;
  logic pop1;
  logic slot_free;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  dpsr_rdw_t head;

  // byte-lane merge, used for both halves of a write burst
  function automatic dpsr_word_t dpsr_merge(
    input dpsr_word_t old,
    input dpsr_word_t d,
    input logic lo_n,
    input logic hi_n
  );
    dpsr_word_t w;
    w = old;
    if (!lo_n) begin
      w[`DPSR_LO_MSB:0] = d[`DPSR_LO_MSB:0];
    end
    if (!hi_n) begin
      w[`DPSR_DATA_W-1:`DPSR_HI_LSB] =
        d[`DPSR_DATA_W-1:`DPSR_HI_LSB];
    end
    dpsr_merge = w;
  endfunction

  function automatic logic [MA-1:0] dpsr_idx(
    input logic [MEM_AW-1:0] a,
    input logic lsb
  );
    dpsr_idx = {a, lsb};
  endfunction

  assign head = dpsr_rdw_t'(fifo_out_data);

  dpsr_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .in_valid_i(r.push_pend),
    .in_ready_o(fifo_in_ready),
    .in_data_i(r.push_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop0 | pop1),
    .out_data_o(fifo_out_data)
  );

  always_comb begin
    next_r = r;
    // ****************************************
    // pin sampling
    // ****************************************
    next_r.s1 = link_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // a clock level counts only once two stages agree
    for (int i = 0; i < 4; i++) begin
      if (r.s2.clks[i] == r.s3.clks[i]) begin
        next_r.clk_f[i] = r.s3.clks[i];
      end
    end
    // sync stages still filling after reset: take the level without an
    // edge, so a clock parked high does not fake a rise
    if (r.fill != 2'h3) begin
      next_r.fill = r.fill + 2'h1;
      next_r.clk_f = r.s2.clks;
    end
    // no edges while clocks stand, so nothing starts or launches; only a read's second fetch goes on
    rise = (r.fill == 2'h3) ? (next_r.clk_f & ~r.clk_f) : 4'h0;
    k_rise = rise[`DPSR_CLK_K];
    kn_rise = rise[`DPSR_CLK_KN];
    c_held = next_r.clk_f[`DPSR_CLK_C] & next_r.clk_f[`DPSR_CLK_CN];
    l_rise = c_held ? k_rise : rise[`DPSR_CLK_C];
    l_nrise = c_held ? kn_rise : rise[`DPSR_CLK_CN];

    // ****************************************
    // write machine
    // ****************************************
    unique case (r.wr_st)
      write_state_idle: begin
        if (k_rise && !r.s3.wr_sel_n) begin
          next_r.mem[dpsr_idx(r.s3.addr[MEM_AW-1:0], 1'b0)] =
            dpsr_merge(r.mem[dpsr_idx(r.s3.addr[MEM_AW-1:0], 1'b0)],
                       r.s3.d, r.s3.low_byte_write_n,
                       r.s3.high_byte_write_n);
          next_r.wr_addr = r.s3.addr[MEM_AW-1:0];
          next_r.wr_st = write_state_go;
        end
      end
      write_state_go: begin
        // strobes sampled afresh for the second half
        if (kn_rise) begin
          next_r.mem[dpsr_idx(r.wr_addr, 1'b1)] =
            dpsr_merge(r.mem[dpsr_idx(r.wr_addr, 1'b1)], r.s3.d,
                       r.s3.low_byte_write_n,
                       r.s3.high_byte_write_n);
          next_r.wr_st = write_state_idle;
        end
      end
      default: begin
        next_r.wr_st = write_state_idle;
      end
    endcase

    // ****************************************
    // read machine, runs beside the write one
    // ****************************************
    if (r.push_pend && fifo_in_ready) begin
      next_r.push_pend = 1'b0;
    end
    slot_free = !r.push_pend || fifo_in_ready;
    accepted = 1'b0;
    unique case (r.rd_st)
      rd_idle: begin
        // refused while the fifo stalls; keeps it from overflowing
        if (k_rise && !r.s3.rd_sel_n && slot_free) begin
          next_r.push_pend = 1'b1;
          next_r.push_word.first = 1'b1;
          next_r.push_word.data =
            r.mem[dpsr_idx(r.s3.addr[MEM_AW-1:0], 1'b0)];
          next_r.rd_addr = r.s3.addr[MEM_AW-1:0];
          next_r.rd_st = rd_second;
          accepted = 1'b1;
        end
      end
      rd_second: begin
        if (slot_free) begin
          next_r.push_pend = 1'b1;
          next_r.push_word.first = 1'b0;
          next_r.push_word.data = r.mem[dpsr_idx(r.rd_addr, 1'b1)];
          next_r.rd_st = rd_idle;
        end
      end
      default: begin
        next_r.rd_st = rd_idle;
      end
    endcase

    // ****************************************
    // output launch
    // ****************************************
    // a load becomes due one K period later
    inc = k_rise & r.load_prev;
    if (k_rise) begin
      next_r.load_prev = accepted;
    end
    pop0 = l_rise && ((r.due != '0) || inc) && fifo_out_valid
           && head.first;
    pop1 = l_nrise && r.second_due && fifo_out_valid
           && !head.first;
    next_r.due = r.due + {{(`DPSR_DUE_W - 1){1'b0}}, inc}
                 - {{(`DPSR_DUE_W - 1){1'b0}}, pop0};
    if (l_rise) begin
      next_r.second_due = pop0;
      next_r.q_oe_n = !pop0;
      if (pop0) begin
        next_r.q = head.data;
      end
    end else if (l_nrise) begin
      next_r.second_due = 1'b0;
      next_r.q_oe_n = !pop1;
      if (pop1) begin
        next_r.q = head.data;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      r <= '0;
      r.rd_st <= rd_idle;
      r.wr_st <= write_state_idle;
      r.q_oe_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.q;
  assign q_oe_n_o = r.q_oe_n;
endmodule

// >>> sim/dpsr_top_asserts.sv
// checker on the ports of the sram interface top
`timescale 1ns/1ps
module dpsr_top_asserts (
  input logic clk_sys_i,
  input logic resetn_i,
  input dpsr_pkg::dpsr_link_t link_i,
  input dpsr_pkg::dpsr_word_t q_o,
  input logic q_oe_n_o
);
  import dpsr_pkg::*;
  logic [3:0] clk_q;
  logic rd_seen;
  logic [3:0] quiet;
  logic [5:0] idle;
  // quiet: cycles since a link clock moved; idle: since a read load
  always_ff @(posedge clk_sys_i) begin
    clk_q <= link_i.clks;
    if (!resetn_i) begin
      rd_seen <= 1'b0;
      quiet <= 4'h0;
      idle <= 6'h0;
    end else begin
      quiet <= (clk_q != link_i.clks) ? 4'h0 : quiet + 4'(quiet != 4'hF);
      if (link_i.clks[3] && !clk_q[3] && !link_i.rd_sel_n) begin
        rd_seen <= 1'b1;
        idle <= 6'h0;
      end else begin
        idle <= idle + 6'(idle != 6'h3F);
      end
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence drive_hold;
    !q_oe_n_o [*3];
  endsequence
  sequence word_hold;
    $stable(q_o) [*2];
  endsequence
  chk_reset_hiz: assert property ($rose(resetn_i) |-> q_oe_n_o)
    else $error("q driven after reset");
  chk_stop_hold: assert property (quiet == 4'hF |->
    $stable(q_o) && $stable(q_oe_n_o)) else $error("q moved, clocks still");
  chk_q_paced: assert property ($changed(q_o) |-> quiet < 4'h8)
    else $error("q changed without launch edge");
  chk_oe_paced: assert property ($rose(q_oe_n_o) |-> quiet < 4'h8)
    else $error("q released without clock edge");
  chk_rd_cause: assert property ($fell(q_oe_n_o) |-> rd_seen)
    else $error("q driven with no read");
  chk_idle_hiz: assert property (idle == 6'h3F |-> q_oe_n_o)
    else $error("q driven long after last read");
  chk_drive_hold: assert property ($fell(q_oe_n_o) |-> drive_hold)
    else $error("q drive too short");
  chk_word_hold: assert property ($changed(q_o) |=> word_hold)
    else $error("q word too short");
endmodule
bind dpsr_top dpsr_top_asserts u_chk (.clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i), .link_i(link_i), .q_o(q_o), .q_oe_n_o(q_oe_n_o));

// >>> sim/dpsr_ctrl_model.sv
// controller model: clocks, selects, address, strobes and write data
`timescale 1ns/1ps
module dpsr_ctrl_model (
  input logic clk_sys_i,
  output dpsr_pkg::dpsr_link_t link_o
);
  import dpsr_pkg::*;
  // parked: K low, K# high, C low, C# high, pairs complementary
  initial begin
    link_o = '1;
    link_o.clks = 4'h5;
  end
  // one K period of 8 sys clocks; ch holds C and C# high
  // s: low, high strobe of first half, then of second half
  task automatic kper(input logic rdn, input logic wrn,
    input logic [17:0] a, input dpsr_word_t d0, input dpsr_word_t d1,
    input logic [3:0] s, input logic ch);
    link_o = '{{2'b10, ch, 1'b1}, rdn, wrn, s[0], s[1], a, d0};
    @(negedge clk_sys_i);
    link_o.clks[1:0] = {1'b1, ch};
    repeat (3) @(negedge clk_sys_i);
    // selects flipped at K# so a late sample shows; address inverted
    link_o = '{{2'b01, 1'b1, ch}, !rdn, !wrn, s[2], s[3], ~a, d1};
    @(negedge clk_sys_i);
    link_o.clks[1:0] = {ch, 1'b1};
    repeat (3) @(negedge clk_sys_i);
  endtask
endmodule

// >>> sim/dpsr_top_bench.sv
// self-checking bench for the sram interface top
`timescale 1ns/1ps
module dpsr_top_bench;
  import dpsr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic oe_q = 1'b1;
  logic q_oe_n;
  dpsr_link_t link;
  dpsr_word_t q;
  dpsr_word_t got[$];
  int n_fail = 0;
  int cmp_count = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  dpsr_ctrl_model ctl (.clk_sys_i(clk_sys_i), .link_o(link));
  dpsr_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link_i(link),
    .q_o(q), .q_oe_n_o(q_oe_n));
  // one entry per launch; equal words back to back would merge
  // sampled at the falling edge, well after the outputs settle
  always @(negedge clk_sys_i) begin
    if (q_oe_n === 1'b0 && (oe_q || q !== got[$]))
      got.push_back(q);
    oe_q <= q_oe_n;
  end
  task automatic chk(input string n, input dpsr_word_t e, dpsr_word_t g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic idle(input logic ch);
    ctl.kper(1'b1, 1'b1, 18'h3, '1, '1, 4'h0, ch);
  endtask
  task automatic wr(input logic [17:0] a, dpsr_word_t d0, d1, logic [3:0] s);
    ctl.kper(1'b1, 1'b0, a, d0, d1, s, 1'b0);
  endtask
  // read a; the next period may write address 7 beside the burst
  task automatic rd_chk(input logic [17:0] a, logic ch, wrn,
    dpsr_word_t e0, e1);
    got.delete();
    ctl.kper(1'b0, 1'b1, a, '1, '1, 4'h0, ch);
    chk("early", 18'h0, 18'(got.size()));
    ctl.kper(1'b1, wrn, 18'h7, 18'h21234, 18'h1F0F0, 4'h0, ch);
    chk("due0", e0, got[0]);
    repeat (2) idle(ch);
    chk("count", 18'h2, 18'(got.size()));
    chk("word0", e0, got[0]);
    chk("word1", e1, got[1]);
  endtask
  task automatic t_plain();
    chk("oe", 18'h1, {17'h0, q_oe_n});
    wr(18'h3, 18'h15A5A, 18'h0C3C3, 4'h0);
    rd_chk(18'h3, 1'b0, 1'b1, 18'h15A5A, 18'h0C3C3);
  endtask
  task automatic t_bytes();
    wr(18'h5, '1, '1, 4'b0110);
    rd_chk(18'h5, 1'b0, 1'b1, 18'h001FF, 18'h3FE00);
    wr(18'h6, '1, '1, 4'b0011);
    rd_chk(18'h6, 1'b0, 1'b1, 18'h0, 18'h3FFFF);
  endtask
  task automatic t_concur();
    rd_chk(18'h3, 1'b1, 1'b0, 18'h15A5A, 18'h0C3C3);
    rd_chk(18'h7, 1'b0, 1'b1, 18'h21234, 18'h1F0F0);
  endtask
  task automatic t_stop();
    got.delete();
    repeat (2) idle(1'b0);
    chk("idle", 18'h0, 18'(got.size()));
    repeat (40) @(negedge clk_sys_i);
    rd_chk(18'h3, 1'b0, 1'b1, 18'h15A5A, 18'h0C3C3);
  endtask
  initial begin
    repeat (3) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_plain();
    t_bytes();
    t_concur();
    t_stop();
    stop_test();
  end
  // the whole run needs about 280 cycles
  initial begin
    #50000;
    n_fail++;
    stop_test();
  end
endmodule
